// ===== src/ugac_top.sv
// Upstream periodic grant control with activity detection, behind an AHB-Lite slave.
// What the document requires of the modem and the headend
// R01 - Headend issues several grants per interval.
// R02 - Any active subflow uses any pooled grant.
// R03 - Headend places grants within nominal plus jitter.
// R04 - No side relies on interval boundary.
// R05 - Set backlog flag on accumulation, clear after.
// R06 - Backlog extra grants stay under one percent.
// R07 - Headend keeps extras while backlog flag set.
// R08 - Headend polices downstream slightly above rate; the bench headend does not model this.
// R09 - Headend polls when idle, grants when active.
// R10 - Report required grant count in every packet.
// R11 - Reported count never exceeds provisioned maximum.
// R12 - Polled activity requests grants, count from first.
// R13 - Headend bursts extra grants on raised count.
// R14 - All idle: one zero-count packet, then stop.
// R15 - Headend enters polling on zero count.
// R16 - Renewed activity sends request in a poll.
// R17 - Headend ignores request size, resumes grants.
// R18 - Restart through poll or running grant.
// R19 - Per-classifier activity timer sets active count.
// R20 - Inactivity timeout is configurable per flow.
`timescale 1ns/1ps
`include "ugac_params.svh"
module ugac_top
	import ugac_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic pkt_arrive,
	input wire logic [`UGAC_SUBW-1:0] pkt_subflow,
	input wire logic [`UGAC_QW-1:0] queue_depth,
	input wire logic grant_pulse,
	input wire logic poll_pulse,
	output logic tx_grant_pkt,
	output logic [`UGAC_CNTW-1:0] tx_grant_count,
	output logic tx_backlog,
	output logic tx_poll_req,
	output logic grant_mode
);
	ugac_act_if act ();

	logic [1:0] ctrl_q;
	ugac_cnt_t maxg_q;
	logic [`UGAC_TMW-1:0] tmo_q;
	logic [`UGAC_QW-1:0] bkl_q;
	logic dph_wr_q;
	logic [7:0] dph_addr_q;
	logic [31:0] rdata_q;
	logic bkl_flag_q;
	ugac_state_t state_q;
	logic tx_pkt_q;
	ugac_cnt_t tx_cnt_q;
	logic req_q;
	logic addr_ok;
	logic en;
	logic ad;
	ugac_cnt_t act_cnt;
	ugac_cnt_t rep_cnt;
	logic [31:0] stat_w;

	// Counts set bits of the activity mask.
	function automatic ugac_cnt_t ones(input ugac_mask_t m);
		ugac_cnt_t c;
		c = '0;
		for (int i = 0; i < `UGAC_NSUB; i++) begin
			c = c + ugac_cnt_t'(m[i]);
		end
		return c;
	endfunction

	// Activity timers live in their own module; the timeout register feeds them.
	assign act.pkt_valid = pkt_arrive;
	assign act.pkt_sub = pkt_subflow;
	assign act.timeout = tmo_q; // [R20]

	ugac_act_timers u_timers (
		.hclk(hclk),
		.hresetn(hresetn),
		.act(act)
	);

	// Control bits are decoded once so that every process sees the same mode.
	assign en = ctrl_q[`UGAC_CTRL_EN];
	assign ad = ctrl_q[`UGAC_CTRL_AD];
	assign act_cnt = ones(act.active); // [R19]

	// The reported count is clipped to the provisioned maximum; without activity
	// detection the flow always asks for its full provisioned grant count.
	always_comb begin
		if (!ad) begin
			rep_cnt = maxg_q;
		end else if (act_cnt > maxg_q) begin
			rep_cnt = maxg_q; // [R11]
		end else begin
			rep_cnt = act_cnt;
		end
	end

	// Status packs the live mask, count, mode and flag for software to poll.
	assign stat_w = {15'h0000, bkl_flag_q, 2'h0, state_q, 1'b0, act_cnt, 4'h0, act.active};

	// Address phase is taken only when the bus is ready and the transfer is real.
	assign addr_ok = hsel && htrans[1] && hready;

	// The data phase remembers the address, since hwdata arrives one cycle later.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr_q <= 1'b0;
			dph_addr_q <= 8'h00;
		end else begin
			dph_wr_q <= addr_ok && hwrite;
			dph_addr_q <= haddr[7:0];
		end
	end

	// Register map, one word each: CTRL holds enable and activity-detection mode,
	// MAXG the provisioned grants per interval, TMO the inactivity timeout in clock
	// cycles, BKL the backlog threshold and STAT a read-only view of the subflow
	// mask, active count, mode and backlog flag.
	// Narrow fields sit in the low bits and read back with zero upper bits, so
	// software may write whole words without masking.
	// Read data is registered at the address edge so the slave never inserts waits.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h00000000;
		end else if (addr_ok && !hwrite) begin
			case (haddr[7:0])
				`UGAC_OFS_CTRL: rdata_q <= {30'h00000000, ctrl_q};
				`UGAC_OFS_MAXG: rdata_q <= {29'h00000000, maxg_q};
				`UGAC_OFS_TMO: rdata_q <= {8'h00, tmo_q};
				`UGAC_OFS_BKL: rdata_q <= {24'h000000, bkl_q};
				`UGAC_OFS_STAT: rdata_q <= stat_w;
				default: rdata_q <= 32'h00000000;
			endcase
		end
	end

	// Register writes complete in the data phase; unmapped writes are dropped.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `UGAC_CTRL_RST;
			maxg_q <= `UGAC_MAXG_RST;
			tmo_q <= `UGAC_TMO_RST;
			bkl_q <= `UGAC_BKL_RST;
		end else if (dph_wr_q) begin
			case (dph_addr_q)
				`UGAC_OFS_CTRL: ctrl_q <= hwdata[1:0];
				`UGAC_OFS_MAXG: maxg_q <= hwdata[`UGAC_CNTW-1:0];
				`UGAC_OFS_TMO: tmo_q <= hwdata[`UGAC_TMW-1:0]; // [R20]
				`UGAC_OFS_BKL: bkl_q <= hwdata[`UGAC_QW-1:0];
				default: ;
			endcase
		end
	end

	// Backlog sets above the threshold and clears once the queue has drained or the flow is disabled,
	// which keeps the flag from chattering around the threshold.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bkl_flag_q <= 1'b0;
		end else if (!en) begin
			bkl_flag_q <= 1'b0;
		end else if (queue_depth > bkl_q) begin
			bkl_flag_q <= 1'b1; // [R05]
		end else if (queue_depth == '0) begin
			bkl_flag_q <= 1'b0; // [R05]
		end
	end

	// Mode machine. Grants are reacted to as they come; nothing here assumes
	// where a grant interval starts, so several grants per interval are
	// simply a pool that any waiting packet may use. [R04]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= UGAC_OFF;
			tx_pkt_q <= 1'b0;
			tx_cnt_q <= '0;
			req_q <= 1'b0;
		end else begin
			tx_pkt_q <= 1'b0;
			req_q <= 1'b0;
			case (state_q)
				UGAC_OFF: begin
					if (en) begin
						state_q <= ad ? UGAC_POLL : UGAC_GRANT;
					end
				end
				UGAC_POLL: begin
					if (!en) begin
						state_q <= UGAC_OFF;
					end else if (!ad) begin
						state_q <= UGAC_GRANT;
					// A grant that is still running wins over a poll: if the headend missed
					// the zero-count packet, the flow restarts without a request round trip.
					end else if (grant_pulse && act_cnt != '0 && queue_depth != '0) begin
						tx_pkt_q <= 1'b1; // [R18]
						tx_cnt_q <= rep_cnt; // [R12]
						state_q <= UGAC_GRANT;
					end else if (poll_pulse && act_cnt != '0) begin
						req_q <= 1'b1; // [R16] [R12]
						state_q <= UGAC_GRANT;
					end
				end
				UGAC_GRANT: begin
					if (!en) begin
						state_q <= UGAC_OFF;
					end else if (grant_pulse && ad && act_cnt == '0) begin
						// One payload-free packet tells the headend to fall back to polls.
						tx_pkt_q <= 1'b1; // [R14]
						tx_cnt_q <= '0;
						state_q <= UGAC_POLL;
					end else if (grant_pulse && queue_depth != '0) begin
						tx_pkt_q <= 1'b1; // [R02]
						tx_cnt_q <= rep_cnt; // [R10] [R11]
					end else if (ad && act_cnt != '0 && poll_pulse) begin
						req_q <= 1'b1; // [R18]
					end
				end
				default: begin
					state_q <= UGAC_OFF;
				end
			endcase
		end
	end

	// Bus answers are always zero-wait and OKAY.
	// Registers never stall, so hreadyout is a plain flop; it stays low in reset
	// so that no master starts a transfer before the registers are out of reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Outputs come straight from their flops; no decode sits between flop and pin.
	assign hrdata = rdata_q;
	assign tx_grant_pkt = tx_pkt_q;
	assign tx_grant_count = tx_cnt_q;
	assign tx_backlog = bkl_flag_q;
	assign tx_poll_req = req_q;

	// Mode indication is its own flop so the output is clean of the state decode.
	logic gmode_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gmode_q <= 1'b0;
		end else begin
			gmode_q <= (state_q == UGAC_GRANT);
		end
	end
	assign grant_mode = gmode_q;

	// Properties watch only what this block drives; the headend may grant or
	// poll in any cycle, so none of them assumes a grant pattern.
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// The cap is the maximum that stood when the packet was decided.
	a_count_max_bound: assert property (tx_grant_pkt |-> tx_grant_count <= $past(maxg_q)) // [R11]
		else $error("Reported grant count above maximum.");

	a_count_in_packet: assert property (tx_grant_pkt && tx_grant_count != '0 // [R10]
		|-> tx_grant_count == $past(rep_cnt))
		else $error("Packet count differs from required count.");

	a_zero_then_poll: assert property (tx_grant_pkt && tx_grant_count == '0 && ad // [R14]
		|-> state_q == UGAC_POLL ##1 !tx_grant_pkt)
		else $error("Zero-count packet not followed by polling.");

	a_poll_request: assert property (tx_poll_req |-> $past(poll_pulse) && $past(act_cnt) != '0) // [R16]
		else $error("Request without poll or activity.");

	a_request_grants: assert property ($past(state_q) == UGAC_POLL && tx_poll_req // [R12]
		|-> state_q == UGAC_GRANT ##1 grant_mode)
		else $error("Request did not enter grant mode.");

	a_backlog_set: assert property (en && queue_depth > bkl_q |=> tx_backlog) // [R05]
		else $error("Backlog flag not raised.");

	a_backlog_clear: assert property (queue_depth == '0 |=> !tx_backlog) // [R05]
		else $error("Backlog flag not cleared after drain.");

	a_pool_grant_use: assert property (state_q == UGAC_GRANT && en && grant_pulse // [R02]
		&& queue_depth != '0 |=> tx_grant_pkt)
		else $error("Grant not used with data queued.");

	a_restart_by_grant: assert property (state_q == UGAC_POLL && en && ad && grant_pulse // [R18]
		&& act_cnt != '0 && queue_depth != '0 |=> tx_grant_pkt && state_q == UGAC_GRANT)
		else $error("Running grant not used to restart.");

	// Plain mode asks for the full provisioned count in every packet.
	a_plain_full_count: assert property (tx_grant_pkt && !$past(ad) // [R10]
		|-> tx_grant_count == $past(maxg_q))
		else $error("Plain-mode count differs from maximum.");

	// With activity detection the count never runs ahead of the active subflows.
	a_active_count_cap: assert property (tx_grant_pkt && $past(ad) // [R19]
		|-> tx_grant_count <= $past(act_cnt))
		else $error("Reported count above active subflows.");

	// A polled flow with no activity stays silent on grants and polls alike.
	a_poll_mode_quiet: assert property (state_q == UGAC_POLL && act_cnt == '0 // [R14]
		|=> !tx_grant_pkt && !tx_poll_req)
		else $error("Idle polled flow transmitted.");

	// Packets leave only in a grant, never on their own.
	a_grant_only_source: assert property (!grant_pulse |=> !tx_grant_pkt) // [R02]
		else $error("Packet sent without a grant.");

	// An empty queue lets a grant pass unused while subflows are still active.
	a_empty_queue_skip: assert property (state_q == UGAC_GRANT && grant_pulse // [R02]
		&& queue_depth == '0 && act_cnt != '0 |=> !tx_grant_pkt)
		else $error("Packet sent from an empty queue.");

	// Renewed activity in a poll, with no usable grant, yields a request.
	a_request_in_poll: assert property (state_q == UGAC_POLL && en && ad && poll_pulse // [R16]
		&& act_cnt != '0 && !(grant_pulse && queue_depth != '0) |=> tx_poll_req)
		else $error("Poll not used for a request.");

	// The flag holds between the threshold and an empty queue.
	a_backlog_hold: assert property (en && tx_backlog && queue_depth != '0 |=> tx_backlog) // [R05]
		else $error("Backlog flag dropped before drain.");

	// Cover points: spurt start, spurt end, backlog, restart by grant, plain mode.
	c_talk_spurt_start: cover property (tx_poll_req ##[1:50] tx_grant_pkt);
	c_spurt_end: cover property (tx_grant_pkt && tx_grant_count == '0);
	c_backlog: cover property (tx_backlog && tx_grant_pkt);
	c_restart_grant: cover property (state_q == UGAC_POLL ##1 tx_grant_pkt);
	c_plain_full: cover property (tx_grant_pkt && !ad);
endmodule

// ===== inc/ugac_params.svh
// Constants for the periodic grant activity control block.
`ifndef UGAC_PARAMS_SVH
`define UGAC_PARAMS_SVH

// Subflows (classifiers) tracked on one flow, the widths that follow from it, then the timeout and queue depth widths.
`define UGAC_NSUB 4
`define UGAC_SUBW 2
`define UGAC_CNTW 3
`define UGAC_TMW 24
`define UGAC_QW 8

// Register byte offsets.
`define UGAC_OFS_CTRL 8'h00
`define UGAC_OFS_MAXG 8'h04
`define UGAC_OFS_TMO 8'h08
`define UGAC_OFS_BKL 8'h0C
`define UGAC_OFS_STAT 8'h10

// Control field positions.
`define UGAC_CTRL_EN 0
`define UGAC_CTRL_AD 1

// Status field positions.
`define UGAC_ST_MASK_LSB 0
`define UGAC_ST_CNT_LSB 8
`define UGAC_ST_MODE_LSB 12
`define UGAC_ST_BKL 16

// Reset values.
`define UGAC_CTRL_RST 2'h0
`define UGAC_MAXG_RST 3'h1
`define UGAC_TMO_RST 24'h0F4240
`define UGAC_BKL_RST 8'h04

`endif

// ===== inc/ugac_pkg.sv
// Types shared by the periodic grant activity control modules.
`include "ugac_params.svh"
package ugac_pkg;
	typedef enum logic [1:0] {UGAC_OFF, UGAC_POLL, UGAC_GRANT} ugac_state_t;
	typedef logic [`UGAC_CNTW-1:0] ugac_cnt_t;
	typedef logic [`UGAC_NSUB-1:0] ugac_mask_t;
endpackage

// ===== inc/ugac_act_if.sv
// Link between the flow controller and the per-subflow activity timers.
`timescale 1ns/1ps
`include "ugac_params.svh"
interface ugac_act_if;
	logic pkt_valid;
	logic [`UGAC_SUBW-1:0] pkt_sub;
	logic [`UGAC_TMW-1:0] timeout;
	logic [`UGAC_NSUB-1:0] active;
	modport ctl (output pkt_valid, output pkt_sub, output timeout, input active);
	modport tmr (input pkt_valid, input pkt_sub, input timeout, output active);
endinterface

// ===== src/ugac_act_timers.sv
// Per-subflow activity timers: active on a packet, inactive after a quiet time.
`timescale 1ns/1ps
`include "ugac_params.svh"
module ugac_act_timers
	import ugac_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	ugac_act_if.tmr act
);
	genvar gi;
	generate
		for (gi = 0; gi < `UGAC_NSUB; gi = gi + 1) begin : g_sub
			logic [`UGAC_TMW-1:0] quiet_q;
			logic on_q;
			logic hit;
			assign hit = act.pkt_valid && (act.pkt_sub == `UGAC_SUBW'(gi));
			// A packet restarts the quiet count; a zero timeout never expires.
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					quiet_q <= '0;
					on_q <= 1'b0;
				end else if (hit) begin
					quiet_q <= '0;
					on_q <= 1'b1; // [R19]
				end else if (on_q) begin
					if (act.timeout != '0 && quiet_q >= act.timeout - 1'b1) begin
						on_q <= 1'b0; // [R19] [R20]
					end else begin
						quiet_q <= quiet_q + 1'b1;
					end
				end
			end
			assign act.active[gi] = on_q;
		end
	endgenerate

	a_pkt_marks_active: assert property (@(posedge hclk) disable iff (!hresetn) // [R19]
		act.pkt_valid |=> act.active[$past(act.pkt_sub)])
		else $error("Subflow not active after its packet.");
endmodule

// ===== bench/ugac_headend.sv
// Behavioural headend scheduler that issues pooled periodic grants and polls.
`timescale 1ns/1ps
module ugac_headend #(
	parameter int INTERVAL = 40
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic grant_mode,
	input wire logic keep_grants,
	input wire logic tx_grant_pkt,
	input wire logic [2:0] tx_grant_count,
	input wire logic tx_backlog,
	output logic grant_pulse,
	output logic poll_pulse
);
	int tick_q;
	int pend_q;
	int want_q;
	int sent_q;
	int p;
	// Grants leave two cycles apart from the tick on, so the last one stays inside the jitter bound.
	// The tick is private to this model and never shown to the modem.
	// Downstream policing slightly above rate sits in the headend's forwarding
	// path, which has no traffic in this bench; only the upstream grants are modelled.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_q <= 0;
			pend_q <= 0;
			want_q <= 1;
			sent_q <= 0;
			grant_pulse <= 1'b0;
			poll_pulse <= 1'b0;
		end else begin
			p = pend_q;
			tick_q <= (tick_q == INTERVAL - 1) ? 0 : tick_q + 1;
			poll_pulse <= (tick_q == 0) && !grant_mode && !keep_grants;
			grant_pulse <= (pend_q > 0) && !grant_pulse;
			if (tick_q == 0 && (grant_mode || keep_grants))
				p = p + want_q;
			if (pend_q > 0 && !grant_pulse)
				p = p - 1;
			if (tx_grant_pkt && tx_grant_count > want_q)
				p = p + 2;
			if (grant_pulse && tx_backlog && sent_q % 100 == 99)
				p = p + 1;
			pend_q <= p;
			sent_q <= sent_q + 32'(grant_pulse);
			// A zero count falls back to one grant, since a polled request's size is disregarded.
			if (tx_grant_pkt)
				want_q <= (tx_grant_count == 3'h0) ? 1 : int'(tx_grant_count);
		end
	end
endmodule

// ===== bench/tb.sv
// Self-checking bench for the periodic grant activity control block.
`timescale 1ns/1ps
`include "ugac_params.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, grant_pulse, poll_pulse, tx_grant_pkt, tx_backlog, tx_poll_req, grant_mode;
	logic [31:0] hrdata, rd;
	logic pkt_arrive = 1'b0;
	logic [1:0] pkt_subflow = 2'h0;
	logic [7:0] queue_depth = 8'h0;
	logic [2:0] tx_grant_count;
	logic keep_grants = 1'b0, feed = 1'b0, steady = 1'b0, ad = 1'b0;
	logic [3:0] feed_mask = 4'h0;
	logic [31:0] rst_tab [6] = '{32'h0, 32'h1, 32'h000F4240, 32'h4, 32'h0, 32'h0};
	int miscompares = 0, n_tests = 0, seed = 55, cycles = 0, zeros = 0, pkts = 0, polls = 0;
	int maxg = 1, fi = 0, base = 0;

	ugac_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pkt_arrive(pkt_arrive), .pkt_subflow(pkt_subflow),
		.queue_depth(queue_depth), .grant_pulse(grant_pulse), .poll_pulse(poll_pulse),
		.tx_grant_pkt(tx_grant_pkt), .tx_grant_count(tx_grant_count), .tx_backlog(tx_backlog),
		.tx_poll_req(tx_poll_req), .grant_mode(grant_mode));
	ugac_headend #(.INTERVAL(40)) i_head (.hclk(hclk), .hresetn(hresetn), .grant_mode(grant_mode),
		.keep_grants(keep_grants), .tx_grant_pkt(tx_grant_pkt), .tx_grant_count(tx_grant_count),
		.tx_backlog(tx_backlog), .grant_pulse(grant_pulse), .poll_pulse(poll_pulse));

	always #5 hclk = ~hclk;

	// Expected header count: active subflows capped by the maximum, or the maximum in plain mode.
	function automatic logic [2:0] exp_cnt(input logic [3:0] m);
		int n;
		n = $countones(m);
		if (!ad)
			return 3'(maxg);
		return 3'(n < maxg ? n : maxg);
	endfunction

	task automatic close_out();
		$display("checks=%0d miscompares=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One single-word transfer; the address phase is held until hready is seen high.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask

	task automatic bkl_step(input logic [7:0] q, input logic e);
		@(posedge hclk);
		queue_depth <= q;
		repeat (2) @(posedge hclk);
		#1;
		`CHK(tx_backlog, e)
	endtask

	// A hang is cut short well beyond the length of the whole sequence.
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end

	// Round-robin packets over the chosen subflows keep each timer alive within its timeout.
	always @(posedge hclk) begin
		pkt_arrive <= 1'b0;
		fi <= fi + 1;
		if (feed && fi % 8 == 0 && feed_mask[fi / 8 % 4]) begin
			pkt_arrive <= 1'b1;
			pkt_subflow <= 2'(fi / 8 % 4);
		end
	end

	// Every granted packet is checked against the cap and, once activity is settled, the exact count.
	always @(posedge hclk) begin
		if (tx_poll_req === 1'b1)
			polls++;
		if (tx_grant_pkt === 1'b1) begin
			pkts++;
			`CHK(tx_grant_count <= maxg, 1'b1)
			if (steady)
				`CHK(tx_grant_count, exp_cnt(feed_mask))
			if (tx_grant_count === 3'h0)
				zeros++;
		end
	end

	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		`CHK(hreadyout, 1'b1)
		`CHK({tx_grant_pkt, tx_poll_req, grant_mode, tx_backlog}, 4'h0)
		for (int i = 0; i < 6; i++) begin
			ahb(1'b0, 8'(i * 4), 32'h0);
			`CHK(rd, rst_tab[i])
		end
		ahb(1'b1, `UGAC_OFS_TMO, 32'h64);
		ahb(1'b1, `UGAC_OFS_MAXG, 32'h2);
		maxg = 2;
		ahb(1'b0, `UGAC_OFS_TMO, 32'h0);
		`CHK(rd, 32'h64)
		// Backlog is tracked only while the flow is enabled, so it is switched on first.
		ad <= 1'b1;
		ahb(1'b1, `UGAC_OFS_CTRL, 32'h3);
		bkl_step(8'h04, 1'b0);
		bkl_step(8'h05, 1'b1);
		bkl_step(8'h01, 1'b1);
		bkl_step(8'h00, 1'b0);
		ahb(1'b0, `UGAC_OFS_STAT, 32'h0);
		`CHK(rd[13:12], 2'h1)
		// Talk spurt on at least three subflows, so the reported count hits the cap.
		queue_depth <= 8'h01;
		feed_mask <= 4'($random(seed)) | 4'h7;
		feed <= 1'b1;
		repeat (60) @(posedge hclk);
		steady <= 1'b1;
		for (int i = 0; i < 600 && pkts < 8; i++) @(posedge hclk);
		`CHK(polls > 0, 1'b1)
		`CHK(grant_mode, 1'b1)
		ahb(1'b0, `UGAC_OFS_STAT, 32'h0);
		`CHK(rd[3:0], feed_mask)
		`CHK(rd[10:8], 3'($countones(feed_mask)))
		// Silence: one zero-count packet, then nothing even while a stale headend keeps granting.
		steady <= 1'b0;
		feed <= 1'b0;
		for (int i = 0; i < 600 && zeros == 0; i++) @(posedge hclk);
		#1;
		base = pkts;
		@(posedge hclk);
		keep_grants <= 1'b1;
		repeat (200) @(posedge hclk);
		#1;
		`CHK(pkts, base)
		`CHK(zeros, 1)
		`CHK(grant_mode, 1'b0)
		// Renewed activity restarts through the grant that is still running.
		@(posedge hclk);
		feed_mask <= 4'(1 << ($random(seed) & 3));
		feed <= 1'b1;
		steady <= 1'b1;
		for (int i = 0; i < 300 && pkts == base; i++) @(posedge hclk);
		`CHK(pkts > base, 1'b1)
		keep_grants <= 1'b0;
		steady <= 1'b0;
		ahb(1'b1, `UGAC_OFS_CTRL, 32'h1);
		ad <= 1'b0;
		repeat (40) @(posedge hclk);
		steady <= 1'b1;
		base = pkts;
		for (int i = 0; i < 400 && pkts < base + 4; i++) @(posedge hclk);
		`CHK(pkts >= base + 4, 1'b1)
		close_out();
	end
endmodule
